/* src/fle_defs.svh */
`ifndef FLE_DEFS_SVH
`define FLE_DEFS_SVH

// working register file geometry
`define FLE_NUM_REGS     32
`define FLE_REG_W        8

// software port map
`define FLE_OFS_REG_LAST 6'h1f
`define FLE_OFS_STATUS   6'h3f

// status flag bit positions
`define FLE_FLAG_C       3'd0
`define FLE_FLAG_Z       3'd1
`define FLE_FLAG_N       3'd2
`define FLE_FLAG_V       3'd3
`define FLE_FLAG_S       3'd4
`define FLE_FLAG_H       3'd5
`define FLE_FLAG_T       3'd6
`define FLE_FLAG_I       3'd7

// reset values
`define FLE_STATUS_RST   8'h00
`define FLE_REG_RST      8'h00

// low register of each pointer pair
`define FLE_PTR_X_LO     5'h1a
`define FLE_PTR_Y_LO     5'h1c
`define FLE_PTR_Z_LO     5'h1e

// pointer step
`define FLE_PTR_STEP     16'h0001

`endif

/* src/fle_exec.sv */
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
`include "fle_defs.svh"

// Summary of operation
// - zero set/clear forces zero flag, one cycle
// - irq on/off sets/clears global enable, one cycle
// - sign set writes one, only sign flag
// - sign clear writes zero, only sign flag
// - overflow set writes one, only overflow flag
// - overflow clear writes zero, only overflow flag
// - half carry set writes one, one cycle
// - half carry clear writes zero, one cycle
// - post-increment load reads, then bumps pointer
// - pre-decrement load decrements pointer, then reads
// - displacement load reads X/Y/Z plus offset
// - direct load reads constant address, two cycles
// - post-increment store writes, then bumps pointer
// - pre-decrement store decrements, then writes

module fle_exec
	import fle_pkg::*;
(
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          sys_rst_i,
	// instruction issue
	input  wire fle_instr_t    instr_i,
	input  wire logic          instr_valid_i,
	output fle_pkg::fle_instr_t instr_unused_o,
	output logic               instr_ready_o,
	output logic               instr_done_o,
	// software register port
	input  wire logic [5:0]    sw_addr_i,
	input  wire logic [7:0]    sw_wdata_i,
	input  wire logic          sw_wr_i,
	input  wire logic          sw_rd_i,
	output logic      [7:0]    sw_rdata_o,
	// data memory, read data valid in the strobe cycle
	output fle_dmem_req_t      dmem_req_o,
	input  wire logic [7:0]    dmem_rdata_i,
	// status flags
	output logic      [7:0]    status_flag_register_o
);

	fle_state_t       state;
	fle_state_t       next_state;
	logic [7:0]       regs [`FLE_NUM_REGS];
	logic             accept;
	logic             is_mem;
	logic             is_load;
	logic             load_q;
	logic [4:0]       load_rd;
	logic [4:0]       ptr_lo;
	logic [4:0]       ptr_lo_q;
	logic [15:0]      ptr_val;
	logic [15:0]      ptr_now;
	logic [15:0]      next_ptr;
	logic [15:0]      eff_addr;
	logic             ptr_upd;
	logic             flag_hit;
	logic [2:0]       flag_idx;
	logic             flag_val;
	logic             core_we_lo;
	logic             core_we_hi;
	logic [3:0]       core_pair;
	logic [15:0]      core_wdata;
	logic             rf_we_lo;
	logic             rf_we_hi;
	logic [3:0]       rf_pair;
	logic [15:0]      rf_wdata;
	logic             sw_reg_hit;

	// the struct echo port is tied off from a flop with no reset, so it is driven with zero from the first clock edge
	always_ff @(posedge clk_i)
	begin
		instr_unused_o <= '0;
	end

	assign accept     = instr_valid_i && instr_ready_o;
	assign sw_reg_hit = sw_addr_i <= `FLE_OFS_REG_LAST;
	assign is_mem     = instr_i.op inside {indirect_load_op, offset_load_op,
		direct_load_op, indirect_store_op};
	assign is_load    = instr_i.op != indirect_store_op;

	always_comb
	begin
		unique case (instr_i.ptr)
			ptr_y:   ptr_lo = `FLE_PTR_Y_LO;
			ptr_z:   ptr_lo = `FLE_PTR_Z_LO;
			default: ptr_lo = `FLE_PTR_X_LO;
		endcase
	end

	assign ptr_val = {regs[{ptr_lo[4:1], 1'b1}], regs[ptr_lo]};
	assign ptr_now = {regs[{ptr_lo_q[4:1], 1'b1}], regs[ptr_lo_q]};

	// address generation; the pointer arithmetic is 16 bits wide on purpose
	always_comb
	begin
		next_ptr = ptr_val;
		eff_addr = ptr_val;
		ptr_upd  = 1'b0;
		if (instr_i.op == direct_load_op)
			eff_addr = instr_i.addr;
		else if (instr_i.op == offset_load_op)
			eff_addr = ptr_val + {10'h000, instr_i.disp};
		else
		begin
			unique case (instr_i.mode)
				amode_post_inc:
				begin
					next_ptr = ptr_val + `FLE_PTR_STEP;
					ptr_upd  = 1'b1;
				end
				amode_pre_dec:
				begin
					next_ptr = ptr_val - `FLE_PTR_STEP;
					eff_addr = next_ptr;
					ptr_upd  = 1'b1;
				end
				amode_disp:
					eff_addr = ptr_val + {10'h000, instr_i.disp};
				amode_plain:
					eff_addr = ptr_val;
			endcase
		end
	end

	// flag instruction decode
	always_comb
	begin
		flag_hit = 1'b1;
		flag_idx = `FLE_FLAG_C;
		flag_val = 1'b0;
		unique case (instr_i.op)
			carry_set_op:        begin flag_idx = `FLE_FLAG_C; flag_val = 1'b1; end
			carry_clear_op:      begin flag_idx = `FLE_FLAG_C; flag_val = 1'b0; end
			negative_set_op:     begin flag_idx = `FLE_FLAG_N; flag_val = 1'b1; end
			negative_clear_op:   begin flag_idx = `FLE_FLAG_N; flag_val = 1'b0; end
			zero_set_op:         begin flag_idx = `FLE_FLAG_Z; flag_val = 1'b1; end
			zero_clear_op:       begin flag_idx = `FLE_FLAG_Z; flag_val = 1'b0; end
			global_irq_on_op:    begin flag_idx = `FLE_FLAG_I; flag_val = 1'b1; end
			global_irq_off_op:   begin flag_idx = `FLE_FLAG_I; flag_val = 1'b0; end
			sign_set_op:         begin flag_idx = `FLE_FLAG_S; flag_val = 1'b1; end
			sign_clear_op:       begin flag_idx = `FLE_FLAG_S; flag_val = 1'b0; end
			overflow_set_op:     begin flag_idx = `FLE_FLAG_V; flag_val = 1'b1; end
			overflow_clear_op:   begin flag_idx = `FLE_FLAG_V; flag_val = 1'b0; end
			t_flag_set_op:       begin flag_idx = `FLE_FLAG_T; flag_val = 1'b1; end
			t_flag_clear_op:     begin flag_idx = `FLE_FLAG_T; flag_val = 1'b0; end
			half_carry_set_op:   begin flag_idx = `FLE_FLAG_H; flag_val = 1'b1; end
			half_carry_clear_op: begin flag_idx = `FLE_FLAG_H; flag_val = 1'b0; end
			default:             flag_hit = 1'b0;
		endcase
	end

	// a flag instruction beats a software write in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			status_flag_register_o <= `FLE_STATUS_RST;
		else if (accept && flag_hit)
			status_flag_register_o[flag_idx] <= flag_val;
		else if (sw_wr_i && (sw_addr_i == `FLE_OFS_STATUS))
			status_flag_register_o <= sw_wdata_i;
	end

	// core register writes; loads never collide with issue since ready is low
	always_comb
	begin
		core_we_lo = 1'b0;
		core_we_hi = 1'b0;
		core_pair  = 4'h0;
		core_wdata = 16'h0000;
		if ((state == fsm_access) && load_q)
		begin
			core_pair  = load_rd[4:1];
			core_we_lo = !load_rd[0];
			core_we_hi = load_rd[0];
			core_wdata = {dmem_rdata_i, dmem_rdata_i};
		end
		else if (accept)
		begin
			unique case (instr_i.op)
				register_copy_op:
				begin
					core_pair  = instr_i.rd[4:1];
					core_we_lo = !instr_i.rd[0];
					core_we_hi = instr_i.rd[0];
					core_wdata = {regs[instr_i.rr], regs[instr_i.rr]};
				end
				register_pair_copy_op:
				begin
					core_pair  = instr_i.rd[4:1];
					core_we_lo = 1'b1;
					core_we_hi = 1'b1;
					core_wdata = {regs[{instr_i.rr[4:1], 1'b1}], regs[{instr_i.rr[4:1], 1'b0}]};
				end
				immediate_load_op:
				begin
					core_pair  = instr_i.rd[4:1];
					core_we_lo = !instr_i.rd[0];
					core_we_hi = instr_i.rd[0];
					core_wdata = {instr_i.imm, instr_i.imm};
				end
				default:
				begin
					if (is_mem && ptr_upd)
					begin
						core_pair  = ptr_lo[4:1];
						core_we_lo = 1'b1;
						core_we_hi = 1'b1;
						core_wdata = next_ptr;
					end
				end
			endcase
		end
	end

	always_comb
	begin
		rf_we_lo = core_we_lo;
		rf_we_hi = core_we_hi;
		rf_pair  = core_pair;
		rf_wdata = core_wdata;
		if (!core_we_lo && !core_we_hi && sw_wr_i && sw_reg_hit)
		begin
			rf_pair  = sw_addr_i[4:1];
			rf_we_lo = !sw_addr_i[0];
			rf_we_hi = sw_addr_i[0];
			rf_wdata = {sw_wdata_i, sw_wdata_i};
		end
	end

	fle_regfile #(
		.NUM_REGS (`FLE_NUM_REGS),
		.REG_W    (`FLE_REG_W)
	) u_regfile (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.we_lo_i   (rf_we_lo),
		.we_hi_i   (rf_we_hi),
		.pair_i    (rf_pair),
		.wdata_i   (rf_wdata),
		.regs_o    (regs)
	);

	always_comb
	begin
		next_state = fsm_idle;
		unique case (state)
			fsm_idle:   next_state = (accept && is_mem) ? fsm_access : fsm_idle;
			fsm_access: next_state = fsm_idle;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			state         <= fsm_idle;
			instr_ready_o <= 1'b1;
			instr_done_o  <= 1'b0;
		end
		else
		begin
			state         <= next_state;
			instr_ready_o <= next_state == fsm_idle;
			instr_done_o  <= (accept && !is_mem) || (state == fsm_access);
		end
	end

	// memory request registered at issue; the address is the direct addr, the pointer plus disp, the old pointer, or the decremented pointer for pre-decrement
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			dmem_req_o <= '0;
			load_q     <= 1'b0;
			load_rd    <= 5'h00;
			ptr_lo_q   <= `FLE_PTR_X_LO;
		end
		else if (accept && is_mem)
		begin
			dmem_req_o.addr  <= eff_addr;
			dmem_req_o.wdata <= regs[instr_i.rr];
			dmem_req_o.we    <= !is_load;
			dmem_req_o.re    <= is_load;
			load_q           <= is_load;
			load_rd          <= instr_i.rd;
			ptr_lo_q         <= ptr_lo;
		end
		else
		begin
			dmem_req_o.we <= 1'b0;
			dmem_req_o.re <= 1'b0;
			load_q        <= 1'b0;
		end
	end

	// reads return data only in the cycle after the strobe
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			sw_rdata_o <= 8'h00;
		else if (sw_rd_i && sw_reg_hit)
			sw_rdata_o <= regs[sw_addr_i[4:0]];
		else if (sw_rd_i && (sw_addr_i == `FLE_OFS_STATUS))
			sw_rdata_o <= status_flag_register_o;
		else
			sw_rdata_o <= 8'h00;
	end

	property p_zero_ops;
		@(posedge clk_i) disable iff (sys_rst_i)
		accept && (instr_i.op inside {zero_set_op, zero_clear_op})
		|=> status_flag_register_o[`FLE_FLAG_Z] == ($past(instr_i.op) == zero_set_op);
	endproperty
	a_zero_ops: assert property (p_zero_ops)
		else $error("zero flag not forced");

	property p_irq_ops;
		@(posedge clk_i) disable iff (sys_rst_i)
		accept && (instr_i.op inside {global_irq_on_op, global_irq_off_op})
		|=> status_flag_register_o[`FLE_FLAG_I] == ($past(instr_i.op) == global_irq_on_op)
			&& instr_done_o;
	endproperty
	a_irq_ops: assert property (p_irq_ops)
		else $error("global enable not updated");

	property p_sign_set;
		@(posedge clk_i) disable iff (sys_rst_i)
		accept && (instr_i.op == sign_set_op)
		|=> status_flag_register_o == ($past(status_flag_register_o) | 8'h10);
	endproperty
	a_sign_set: assert property (p_sign_set)
		else $error("sign set wrong");

	property p_sign_clear;
		@(posedge clk_i) disable iff (sys_rst_i)
		accept && (instr_i.op == sign_clear_op)
		|=> status_flag_register_o == ($past(status_flag_register_o) & 8'hef);
	endproperty
	a_sign_clear: assert property (p_sign_clear)
		else $error("sign clear wrong");

	property p_ovf_ops;
		@(posedge clk_i) disable iff (sys_rst_i)
		accept && (instr_i.op inside {overflow_set_op, overflow_clear_op})
		|=> ((status_flag_register_o ^ $past(status_flag_register_o)) & 8'hf7) == 8'h00
			&& status_flag_register_o[`FLE_FLAG_V] == ($past(instr_i.op) == overflow_set_op);
	endproperty
	a_ovf_ops: assert property (p_ovf_ops)
		else $error("overflow op wrong");

	property p_half_ops;
		@(posedge clk_i) disable iff (sys_rst_i)
		accept && (instr_i.op inside {half_carry_set_op, half_carry_clear_op})
		|=> status_flag_register_o[`FLE_FLAG_H] == ($past(instr_i.op) == half_carry_set_op);
	endproperty
	a_half_ops: assert property (p_half_ops)
		else $error("half carry op wrong");

	property p_carry_neg;
		@(posedge clk_i) disable iff (sys_rst_i)
		accept && (instr_i.op inside {carry_set_op, carry_clear_op, negative_set_op,
			negative_clear_op})
		|=> ($past(instr_i.op) inside {carry_set_op, carry_clear_op})
			? status_flag_register_o[`FLE_FLAG_C] == ($past(instr_i.op) == carry_set_op)
			: status_flag_register_o[`FLE_FLAG_N] == ($past(instr_i.op) == negative_set_op);
	endproperty
	a_carry_neg: assert property (p_carry_neg)
		else $error("carry or negative op wrong");

	property p_post_load;
		@(posedge clk_i) disable iff (sys_rst_i)
		accept && (instr_i.op == indirect_load_op) && (instr_i.mode == amode_post_inc)
		|=> dmem_req_o.re && (dmem_req_o.addr == $past(ptr_val))
			&& (ptr_now == $past(ptr_val) + 16'h0001)
		##1 instr_done_o && (regs[$past(load_rd)] == $past(dmem_rdata_i));
	endproperty
	a_post_load: assert property (p_post_load)
		else $error("post-increment load wrong");

	property p_pre_load;
		@(posedge clk_i) disable iff (sys_rst_i)
		accept && (instr_i.op == indirect_load_op) && (instr_i.mode == amode_pre_dec)
		|=> dmem_req_o.re && (dmem_req_o.addr == $past(ptr_val) - 16'h0001)
			&& (ptr_now == dmem_req_o.addr);
	endproperty
	a_pre_load: assert property (p_pre_load)
		else $error("pre-decrement load wrong");

	property p_disp_load;
		@(posedge clk_i) disable iff (sys_rst_i)
		accept && (instr_i.op == offset_load_op)
		|=> (dmem_req_o.addr == $past(ptr_val) + {10'h000, $past(instr_i.disp)})
			&& (ptr_now == $past(ptr_val)) && !instr_ready_o;
	endproperty
	a_disp_load: assert property (p_disp_load)
		else $error("displacement load wrong");

	property p_direct_load;
		@(posedge clk_i) disable iff (sys_rst_i)
		accept && (instr_i.op == direct_load_op)
		|=> dmem_req_o.re && (dmem_req_o.addr == $past(instr_i.addr))
			&& $stable(status_flag_register_o)
		##1 instr_done_o && instr_ready_o;
	endproperty
	a_direct_load: assert property (p_direct_load)
		else $error("direct load wrong");

	property p_post_store;
		@(posedge clk_i) disable iff (sys_rst_i)
		accept && (instr_i.op == indirect_store_op) && (instr_i.mode == amode_post_inc)
		|=> dmem_req_o.we && (dmem_req_o.wdata == $past(regs[instr_i.rr]))
			&& (dmem_req_o.addr == $past(ptr_val)) && (ptr_now == dmem_req_o.addr + 16'h0001);
	endproperty
	a_post_store: assert property (p_post_store)
		else $error("post-increment store wrong");

	property p_pre_store;
		@(posedge clk_i) disable iff (sys_rst_i)
		accept && (instr_i.op == indirect_store_op) && (instr_i.mode == amode_pre_dec)
		|=> dmem_req_o.we && (dmem_req_o.addr == $past(ptr_val) - 16'h0001)
		##1 !dmem_req_o.we && instr_done_o;
	endproperty
	a_pre_store: assert property (p_pre_store)
		else $error("pre-decrement store wrong");

	property p_copy;
		@(posedge clk_i) disable iff (sys_rst_i)
		accept && (instr_i.op == register_copy_op) && (instr_i.rd != instr_i.rr)
		|=> (regs[$past(instr_i.rd)] == $past(regs[instr_i.rr])) && instr_done_o;
	endproperty
	a_copy: assert property (p_copy)
		else $error("register copy wrong");

endmodule : fle_exec

/* src/fle_pkg.sv */
package fle_pkg;

	typedef enum logic [4:0] {
		no_op,
		carry_set_op,
		carry_clear_op,
		negative_set_op,
		negative_clear_op,
		zero_set_op,
		zero_clear_op,
		global_irq_on_op,
		global_irq_off_op,
		sign_set_op,
		sign_clear_op,
		overflow_set_op,
		overflow_clear_op,
		t_flag_set_op,
		t_flag_clear_op,
		half_carry_set_op,
		half_carry_clear_op,
		register_copy_op,
		register_pair_copy_op,
		immediate_load_op,
		indirect_load_op,
		offset_load_op,
		direct_load_op,
		indirect_store_op
	} fle_op_t;

	typedef enum logic [1:0] {
		amode_plain,
		amode_post_inc,
		amode_pre_dec,
		amode_disp
	} fle_amode_t;

	typedef enum logic [1:0] {
		ptr_x,
		ptr_y,
		ptr_z
	} fle_ptr_t;

	typedef struct packed {
		fle_op_t    op;
		fle_amode_t mode;
		fle_ptr_t   ptr;
		logic [4:0] rd;
		logic [4:0] rr;
		logic [7:0] imm;
		logic [5:0] disp;
		logic [15:0] addr;
	} fle_instr_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        we;
		logic        re;
	} fle_dmem_req_t;

	typedef enum logic {
		fsm_idle,
		fsm_access
	} fle_state_t;

endpackage : fle_pkg

/* src/fle_regfile.sv */
`timescale 1ns/1ps
`include "fle_defs.svh"

module fle_regfile
	import fle_pkg::*;
#(
	parameter int NUM_REGS = `FLE_NUM_REGS,
	parameter int REG_W    = `FLE_REG_W,
	parameter int PAIR_W   = $clog2(NUM_REGS) - 1
)(
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              sys_rst_i,
	// pair-wide write port with byte enables
	input  wire logic              we_lo_i,
	input  wire logic              we_hi_i,
	input  wire logic [PAIR_W-1:0] pair_i,
	input  wire logic [2*REG_W-1:0] wdata_i,
	// every register visible at once
	output logic      [REG_W-1:0]  regs_o [NUM_REGS]
);

	logic [REG_W-1:0] mem [NUM_REGS];

	genvar g;
	generate
		for (g = 0; g < NUM_REGS; g++)
		begin : g_reg
			localparam logic [PAIR_W-1:0] PAIR = PAIR_W'(g / 2);
			localparam bit                HIGH = (g % 2) == 1;
			always_ff @(posedge clk_i)
			begin
				if (sys_rst_i)
					mem[g] <= `FLE_REG_RST;
				else if ((pair_i == PAIR) && (HIGH ? we_hi_i : we_lo_i))
					mem[g] <= HIGH ? wdata_i[2*REG_W-1:REG_W] : wdata_i[REG_W-1:0];
			end
			assign regs_o[g] = mem[g];
		end
	endgenerate

endmodule : fle_regfile

/* testbench/fle_mem_model.sv */
`timescale 1ns/1ps
module fle_mem_model
	import fle_pkg::*;
(
	// clock
	input  wire logic          clk_i,
	// request from the block
	input  wire fle_dmem_req_t req_i,
	output logic [7:0]         rdata_o
);
	logic [7:0] mem [65536];
	bit         written [65536];
	logic [7:0] last = 8'h00;

	// unwritten bytes give a pattern of their address
	function automatic logic [7:0] fle_pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction : fle_pat

	always_ff @(posedge clk_i)
	begin
		if (req_i.we)
		begin
			mem[req_i.addr]     <= req_i.wdata;
			written[req_i.addr] <= 1'b1;
		end
		last <= rdata_o;
	end

	// read is combinational; outside a read the bus shows the inverse of its value in the previous cycle
	always_comb
	begin
		if (!req_i.re)
			rdata_o = ~last;
		else if (written[req_i.addr])
			rdata_o = mem[req_i.addr];
		else
			rdata_o = fle_pat(req_i.addr);
	end
endmodule : fle_mem_model

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench
	import fle_pkg::*;
;
	logic          clk_i = 1'b0;
	logic          sys_rst_i = 1'b1;
	fle_instr_t    instr_i = '0;
	logic          instr_valid_i = 1'b0;
	logic          rdy;
	logic          done;
	fle_instr_t    spare;
	logic [5:0]    sw_addr_i = 6'h00;
	logic [7:0]    sw_wdata_i = 8'h00;
	logic          sw_wr_i = 1'b0;
	logic          sw_rd_i = 1'b0;
	logic [7:0]    sw_rdata_o;
	fle_dmem_req_t dmem_req_o;
	logic [7:0]    dmem_rdata_i;
	logic [7:0]    flags;
	int            bad_count = 0;
	int            total_checks = 0;

	initial forever #10 clk_i = ~clk_i;

	fle_exec u_dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .instr_i(instr_i),
		.instr_valid_i(instr_valid_i), .instr_unused_o(spare), .instr_ready_o(rdy),
		.instr_done_o(done), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i),
		.sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
		.dmem_req_o(dmem_req_o), .dmem_rdata_i(dmem_rdata_i),
		.status_flag_register_o(flags)
	);

	fle_mem_model u_mem (.clk_i(clk_i), .req_i(dmem_req_o), .rdata_o(dmem_rdata_i));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	function automatic fle_instr_t mk(fle_op_t op, fle_amode_t m, fle_ptr_t p,
		logic [4:0] rd, logic [4:0] rr, logic [7:0] imm, logic [5:0] d, logic [15:0] a);
		fle_instr_t i;
		i = '0;
		i.op = op;
		i.mode = m;
		i.ptr = p;
		i.rd = rd;
		i.rr = rr;
		i.imm = imm;
		i.disp = d;
		i.addr = a;
		return i;
	endfunction : mk

	task automatic sw_write(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_i);
		sw_addr_i <= a;
		sw_wdata_i <= d;
		sw_wr_i <= 1'b1;
		@(posedge clk_i);
		sw_wr_i <= 1'b0;
	endtask : sw_write

	task automatic sw_read(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		sw_addr_i <= a;
		sw_rd_i <= 1'b1;
		@(posedge clk_i);
		sw_rd_i <= 1'b0;
		#1 check(sw_rdata_o, exp, "sw read");
	endtask : sw_read

	// issue one instruction while idle and judge its timing at the memory port
	task automatic run(input fle_instr_t i, input logic [15:0] ea, input logic is_wr,
		input logic [7:0] wd);
		@(posedge clk_i);
		instr_i <= i;
		instr_valid_i <= 1'b1;
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		#1;
		if (i.op < indirect_load_op)
			check(done, 1'b1, "one cycle done");
		else
		begin
			check({rdy, done, dmem_req_o.re, dmem_req_o.we}, {2'b00, !is_wr, is_wr},
				"access");
			check(dmem_req_o.addr, ea, "mem addr");
			if (is_wr)
				check(dmem_req_o.wdata, wd, "store data");
			@(posedge clk_i);
			#1 check({rdy, done, dmem_req_o.re, dmem_req_o.we}, 4'b1100, "two cycle done");
		end
		// done is a single pulse; ready must already be back
		@(posedge clk_i);
		#1 check({rdy, done}, 2'b10, "done pulse");
	endtask : run

	task automatic put_const(input logic [4:0] r, input logic [7:0] v);
		run(mk(immediate_load_op, amode_plain, ptr_x, r, 5'h00, v, 6'h00, 16'h0000),
			16'h0000, 1'b0, 8'h00);
	endtask : put_const

	task automatic t_reset();
		sw_read(6'h3f, 8'h00);
		sw_read(6'h1a, 8'h00);
		sw_write(6'h20, 8'hff);
		sw_read(6'h20, 8'h00);
		sw_write(6'h05, 8'h77);
		sw_read(6'h05, 8'h77);
		@(posedge clk_i);
		#1 check(sw_rdata_o, 8'h00, "read data one cycle");
		check({15'h0000, |spare}, 16'h0000, "spare port tied off");
		$display("test reset done");
	endtask : t_reset

	// ordered by flag bit, carry first; each op must touch only its own bit
	task automatic t_flags();
		fle_op_t    sets [8] = '{carry_set_op, zero_set_op, negative_set_op, overflow_set_op,
			sign_set_op, half_carry_set_op, t_flag_set_op, global_irq_on_op};
		fle_op_t    clrs [8] = '{carry_clear_op, zero_clear_op, negative_clear_op,
			overflow_clear_op, sign_clear_op, half_carry_clear_op, t_flag_clear_op,
			global_irq_off_op};
		logic [7:0] exp;
		exp = 8'h00;
		for (int k = 0; k < 8; k++)
		begin
			run(mk(sets[k], amode_plain, ptr_x, 5'h00, 5'h00, 8'h00, 6'h00, 16'h0000),
				16'h0000, 1'b0, 8'h00);
			exp[k] = 1'b1;
			check(flags, exp, "flag set");
		end
		sw_read(6'h3f, 8'hff);
		for (int k = 0; k < 8; k++)
		begin
			run(mk(clrs[k], amode_plain, ptr_x, 5'h00, 5'h00, 8'h00, 6'h00, 16'h0000),
				16'h0000, 1'b0, 8'h00);
			exp[k] = 1'b0;
			check(flags, exp, "flag clear");
		end
		sw_write(6'h3f, 8'h81);
		run(mk(zero_set_op, amode_plain, ptr_x, 5'h00, 5'h00, 8'h00, 6'h00, 16'h0000),
			16'h0000, 1'b0, 8'h00);
		check(flags, 8'h83, "other flags kept");
		$display("test flags done");
	endtask : t_flags

	task automatic t_copy();
		put_const(5'd16, 8'ha5);
		put_const(5'd17, 8'h3c);
		run(mk(register_copy_op, amode_plain, ptr_x, 5'd4, 5'd16, 8'h00, 6'h00, 16'h0000),
			16'h0000, 1'b0, 8'h00);
		run(mk(register_pair_copy_op, amode_plain, ptr_x, 5'd2, 5'd16, 8'h00, 6'h00,
			16'h0000), 16'h0000, 1'b0, 8'h00);
		sw_read(6'h04, 8'ha5);
		sw_read(6'h02, 8'ha5);
		sw_read(6'h03, 8'h3c);
		$display("test copy done");
	endtask : t_copy

	task automatic t_loads();
		put_const(5'h1a, 8'hff);
		put_const(5'h1b, 8'hff);
		run(mk(indirect_load_op, amode_post_inc, ptr_x, 5'd20, 5'h00, 8'h00, 6'h00,
			16'h0000), 16'hffff, 1'b0, 8'h00);
		sw_read(6'd20, 8'h5a);
		sw_read(6'h1a, 8'h00);
		sw_read(6'h1b, 8'h00);
		run(mk(indirect_load_op, amode_pre_dec, ptr_y, 5'd21, 5'h00, 8'h00, 6'h00,
			16'h0000), 16'hffff, 1'b0, 8'h00);
		sw_read(6'd21, 8'h5a);
		sw_read(6'h1d, 8'hff);
		put_const(5'h1f, 8'h01);
		run(mk(offset_load_op, amode_disp, ptr_z, 5'd22, 5'h00, 8'h00, 6'h3f, 16'h0000),
			16'h013f, 1'b0, 8'h00);
		sw_read(6'd22, 8'h64);
		sw_read(6'h1e, 8'h00);
		sw_read(6'h1f, 8'h01);
		run(mk(direct_load_op, amode_plain, ptr_x, 5'd23, 5'h00, 8'h00, 6'h00, 16'h1234),
			16'h1234, 1'b0, 8'h00);
		sw_read(6'd23, 8'h7c);
		check(flags, 8'h83, "flags after loads");
		$display("test loads done");
	endtask : t_loads

	task automatic t_stores();
		run(mk(indirect_store_op, amode_post_inc, ptr_z, 5'h00, 5'd16, 8'h00, 6'h00,
			16'h0000), 16'h0100, 1'b1, 8'ha5);
		sw_read(6'h1e, 8'h01);
		run(mk(indirect_store_op, amode_pre_dec, ptr_x, 5'h00, 5'd17, 8'h00, 6'h00,
			16'h0000), 16'hffff, 1'b1, 8'h3c);
		sw_read(6'h1a, 8'hff);
		run(mk(indirect_load_op, amode_plain, ptr_x, 5'd24, 5'h00, 8'h00, 6'h00, 16'h0000),
			16'hffff, 1'b0, 8'h00);
		sw_read(6'd24, 8'h3c);
		run(mk(indirect_load_op, amode_pre_dec, ptr_z, 5'd25, 5'h00, 8'h00, 6'h00,
			16'h0000), 16'h0100, 1'b0, 8'h00);
		sw_read(6'd25, 8'ha5);
		run(mk(indirect_store_op, amode_plain, ptr_z, 5'h00, 5'd17, 8'h00, 6'h00,
			16'h0000), 16'h0100, 1'b1, 8'h3c);
		sw_read(6'h1e, 8'h00);
		run(mk(indirect_load_op, amode_disp, ptr_y, 5'd5, 5'h00, 8'h00, 6'h01,
			16'h0000), 16'h0000, 1'b0, 8'h00);
		sw_read(6'h05, 8'h5a);
		sw_read(6'h1d, 8'hff);
		check(flags, 8'h83, "flags after stores");
		$display("test stores done");
	endtask : t_stores

	// an op offered while ready is low is dropped; an instruction beats software
	task automatic t_collide();
		@(posedge clk_i);
		instr_i <= mk(direct_load_op, amode_plain, ptr_x, 5'd10, 5'h00, 8'h00, 6'h00,
			16'h0000);
		instr_valid_i <= 1'b1;
		@(posedge clk_i);
		instr_i <= mk(carry_clear_op, amode_plain, ptr_x, 5'h00, 5'h00, 8'h00, 6'h00,
			16'h0000);
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		#1 check(flags, 8'h83, "refused while busy");
		sw_read(6'd10, 8'h5a);
		@(posedge clk_i);
		instr_valid_i <= 1'b1;
		sw_addr_i <= 6'h3f;
		sw_wdata_i <= 8'h00;
		sw_wr_i <= 1'b1;
		@(posedge clk_i);
		instr_i <= mk(immediate_load_op, amode_plain, ptr_x, 5'd11, 5'h00, 8'h11, 6'h00,
			16'h0000);
		sw_addr_i <= 6'h0c;
		sw_wdata_i <= 8'h22;
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		sw_wr_i <= 1'b0;
		#1 check(flags, 8'h82, "instruction beats software");
		sw_read(6'h0b, 8'h11);
		sw_read(6'h0c, 8'h00);
		$display("test collide done");
	endtask : t_collide

	initial
	begin
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_flags();
		t_copy();
		t_loads();
		t_stores();
		t_collide();
		end_of_test();
	end

	// the tests need well under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		end_of_test();
	end
endmodule : testbench
